/* File: rtl/eirq_pkg.sv */
// package: constants for the extended interrupt and nibble port block
// Operation
// - control register at 0C0H, bit addressable
// - priority bit selects high or low level
// - enable bits 2 and 6 gate service
// - edge-select bit: falling edge, else level
// - edge flag set on edge, cleared on service
// - eight vectors, fixed polling order per level
// - added inputs behave like standard external interrupts
// - nibble port at 0D8H, four pins
// - port like first port, pins feed interrupts
// - byte write drives pins, reads, read-modify-write
// - bidirectional pins with internal pull-ups
// - reset: port latch FFH, control 00H
package eirq_pkg;
  localparam logic [7:0] EIRQ_CTRL_ADDR = 8'hC0;
  localparam logic [7:0] EIRQ_PORT_ADDR = 8'hD8;
  localparam logic [7:0] EIRQ_CTRL_RESET = 8'h00;
  localparam logic [7:0] EIRQ_PORT_RESET = 8'hFF;
  localparam int EIRQ_IRQ2_EDGE_BIT = 0;
  localparam int EIRQ_IRQ2_PEND_BIT = 1;
  localparam int EIRQ_IRQ2_EN_BIT = 2;
  localparam int EIRQ_IRQ2_HIGH_BIT = 3;
  localparam int EIRQ_IRQ3_EDGE_BIT = 4;
  localparam int EIRQ_IRQ3_PEND_BIT = 5;
  localparam int EIRQ_IRQ3_EN_BIT = 6;
  localparam int EIRQ_IRQ3_HIGH_BIT = 7;
  localparam int EIRQ_NSRC = 8;
  localparam int EIRQ_PORT_W = 4;
  localparam int EIRQ_IRQ2_PIN = 2;
  localparam int EIRQ_IRQ3_PIN = 3;
  localparam logic [7:0] EIRQ_VEC_BASE = 8'h03;
  localparam logic [7:0] EIRQ_VEC_STEP = 8'h08;
  // position 6 and 7 in the polling order
  localparam int EIRQ_SRC_IRQ2 = 6;
  localparam int EIRQ_SRC_IRQ3 = 7;

  function automatic logic [7:0] eirq_vector(input logic [2:0] idx);
    eirq_vector = 8'(EIRQ_VEC_BASE + EIRQ_VEC_STEP * {5'h00, idx});
  endfunction

  function automatic logic [3:0] eirq_pick(input logic [7:0] req);
    logic [3:0] r;
    r = 4'h0;
    for (int i = EIRQ_NSRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    eirq_pick = r;
  endfunction
endpackage

/* File: rtl/eirq_src_if.sv */
// interface: one added external interrupt source and its control bits
`timescale 1ns/1ps
`default_nettype none
interface eirq_src_if;
  logic pin;
  logic edge_sel;
  logic clr_by_service;
  logic sw_wr;
  logic sw_val;
  logic pending;
  logic request;
  modport src (input pin, edge_sel, clr_by_service, sw_wr, sw_val, output pending, request);
  modport ctl (output pin, edge_sel, clr_by_service, sw_wr, sw_val, input pending, request);
endinterface
`default_nettype wire

/* File: rtl/eirq_detect.sv */
// module: edge or level detection for one added external interrupt
`timescale 1ns/1ps
`default_nettype none
module eirq_detect
  import eirq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // source
  eirq_src_if.src s
);
  logic pin_d_ff, nxt_pin_d;
  logic flag_ff, nxt_flag;

  always_comb begin
    nxt_pin_d = s.pin;
    nxt_flag = flag_ff;
    if (s.edge_sel) begin
      if (s.clr_by_service) begin
        nxt_flag = 1'b0;
      end
      if (s.sw_wr) begin
        nxt_flag = s.sw_val;
      end
      if (pin_d_ff && !s.pin) begin
        nxt_flag = 1'b1;
      end
    end else begin
      // level mode: flag follows the low pin
      nxt_flag = !s.pin;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_d_ff <= 1'b1;
      flag_ff <= 1'b0;
    end else begin
      pin_d_ff <= nxt_pin_d;
      flag_ff <= nxt_flag;
    end
  end

  assign s.pending = flag_ff;
  assign s.request = flag_ff;
endmodule // eirq_detect
`default_nettype wire

/* File: rtl/eirq_top.sv */
// module: extra interrupt control, eight-source vectoring and nibble port
`timescale 1ns/1ps
`default_nettype none
module eirq_top
  import eirq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // special-function register bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  input wire logic sfr_bit_wr,
  input wire logic [7:0] sfr_bit_addr,
  input wire logic sfr_bit_val,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // standard sources from the core, positions 0..5
  input wire logic [5:0] std_req,
  input wire logic [5:0] std_high,
  // interrupt handshake with the core
  output logic irq_req,
  output logic [7:0] irq_vector,
  output logic [2:0] irq_source,
  input wire logic irq_ack,
  input wire logic irq_reti,
  // nibble port pins
  input wire logic [3:0] nibble_port_in,
  output logic [3:0] nibble_port_out,
  output logic [3:0] nibble_port_oe_n,
  output logic [3:0] nibble_port_pullup
);
  logic rst_s1_ff, rst_n_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end

  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [3:0] port_ff, nxt_port;
  logic [1:0] act_ff, nxt_act;
  logic act_hi_src_ok, act_lo_src_ok;
  logic [2:0] act_src_ff [2];
  logic [2:0] nxt_act_src [2];
  logic [7:0] nxt_rdata, nxt_vector;
  logic [2:0] nxt_source;
  logic p2_bit, p3_bit;

  eirq_src_if i2 ();
  eirq_src_if i3 ();

  logic ctrl_sel, port_sel, ctrl_bsel, port_bsel;
  logic [2:0] bidx;
  assign ctrl_sel = (sfr_addr == EIRQ_CTRL_ADDR);
  assign port_sel = (sfr_addr == EIRQ_PORT_ADDR);
  // a bit address names its byte by the upper five bits
  function automatic logic bit_in_byte(input logic [7:0] baddr, input logic [7:0] byte_addr);
    bit_in_byte = (baddr[7:3] == byte_addr[7:3]);
  endfunction

  // bit form aimed at one pending bit of the control byte
  function automatic logic pend_bit_sel(input logic bsel, input logic [2:0] idx, input int pos);
    pend_bit_sel = bsel && (idx == 3'(pos));
  endfunction

  assign ctrl_bsel = sfr_bit_wr && bit_in_byte(sfr_bit_addr, EIRQ_CTRL_ADDR);
  assign port_bsel = sfr_bit_wr && bit_in_byte(sfr_bit_addr, EIRQ_PORT_ADDR);
  assign bidx = sfr_bit_addr[2:0];
  assign sfr_hit = ctrl_sel || port_sel;

  assign i2.pin = nibble_port_in[EIRQ_IRQ2_PIN];
  assign i3.pin = nibble_port_in[EIRQ_IRQ3_PIN];
  assign i2.edge_sel = ctrl_ff[EIRQ_IRQ2_EDGE_BIT];
  assign i3.edge_sel = ctrl_ff[EIRQ_IRQ3_EDGE_BIT];
  // bit form wins over a byte write landing in the same cycle
  assign p2_bit = pend_bit_sel(ctrl_bsel, bidx, EIRQ_IRQ2_PEND_BIT);
  assign p3_bit = pend_bit_sel(ctrl_bsel, bidx, EIRQ_IRQ3_PEND_BIT);
  assign i2.sw_wr = (sfr_wr && ctrl_sel) || p2_bit;
  assign i3.sw_wr = (sfr_wr && ctrl_sel) || p3_bit;
  assign i2.sw_val = p2_bit ? sfr_bit_val : sfr_wdata[EIRQ_IRQ2_PEND_BIT];
  assign i3.sw_val = p3_bit ? sfr_bit_val : sfr_wdata[EIRQ_IRQ3_PEND_BIT];

  eirq_detect u_det2 (.clk(clk), .rst_n(rst_n_ff), .s(i2));
  eirq_detect u_det3 (.clk(clk), .rst_n(rst_n_ff), .s(i3));

  // arbitration
  logic [7:0] req, hi_req;
  logic [3:0] pick_hi, pick_lo;
  logic grant_ok, grant_hi;
  logic [2:0] grant_src;
  assign req = {i3.request && ctrl_ff[EIRQ_IRQ3_EN_BIT], i2.request && ctrl_ff[EIRQ_IRQ2_EN_BIT], std_req};
  assign hi_req = req & {ctrl_ff[EIRQ_IRQ3_HIGH_BIT], ctrl_ff[EIRQ_IRQ2_HIGH_BIT], std_high};
  assign pick_hi = eirq_pick(hi_req);
  assign pick_lo = eirq_pick(req & ~hi_req);
  assign act_hi_src_ok = !act_ff[1] && pick_hi[3];
  assign act_lo_src_ok = !act_ff[1] && !act_ff[0] && pick_lo[3];
  assign grant_ok = act_hi_src_ok || act_lo_src_ok;
  assign grant_hi = act_hi_src_ok;
  assign grant_src = act_hi_src_ok ? pick_hi[2:0] : pick_lo[2:0];
  assign irq_req = grant_ok;
  assign i2.clr_by_service = irq_ack && grant_ok && grant_src == 3'(EIRQ_SRC_IRQ2);
  assign i3.clr_by_service = irq_ack && grant_ok && grant_src == 3'(EIRQ_SRC_IRQ3);

  // register group: control byte and port latch
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_port = port_ff;
    if (sfr_wr && ctrl_sel) begin
      nxt_ctrl = sfr_wdata;
    end
    if (ctrl_bsel) begin
      nxt_ctrl[bidx] = sfr_bit_val;
    end
    nxt_ctrl[EIRQ_IRQ2_PEND_BIT] = i2.pending;
    nxt_ctrl[EIRQ_IRQ3_PEND_BIT] = i3.pending;
    if (sfr_wr && port_sel) begin
      nxt_port = sfr_wdata[EIRQ_PORT_W-1:0];
    end
    // upper bits have no pins, so bit writes there are dropped
    if (port_bsel && bidx < 3'(EIRQ_PORT_W)) begin
      nxt_port[bidx[1:0]] = sfr_bit_val;
    end
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ctrl_ff <= EIRQ_CTRL_RESET;
      port_ff <= EIRQ_PORT_RESET[EIRQ_PORT_W-1:0];
    end else begin
      ctrl_ff <= nxt_ctrl;
      port_ff <= nxt_port;
    end
  end

  // service group: active levels and the source taken at each
  always_comb begin
    nxt_act = act_ff;
    nxt_act_src = act_src_ff;
    // return ends the highest active level
    if (irq_reti) begin
      if (act_ff[1]) begin
        nxt_act[1] = 1'b0;
      end else begin
        nxt_act[0] = 1'b0;
      end
    end
    if (irq_ack && grant_ok) begin
      nxt_act[grant_hi] = 1'b1;
      nxt_act_src[grant_hi] = grant_src;
    end
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      act_ff <= 2'h0;
      act_src_ff[0] <= 3'h0;
      act_src_ff[1] <= 3'h0;
    end else begin
      act_ff <= nxt_act;
      act_src_ff <= nxt_act_src;
    end
  end

  // output group: vector, source and read data
  always_comb begin
    nxt_vector = eirq_vector(grant_src);
    nxt_source = grant_src;
    nxt_rdata = sfr_rdata;
    // rmw reads latch, plain read reads pins
    if (sfr_rd && ctrl_sel) begin
      nxt_rdata = ctrl_ff;
    end else if (sfr_rd && port_sel) begin
      nxt_rdata = {4'hF, sfr_rmw ? port_ff : nibble_port_in};
    end
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      irq_vector <= 8'h00;
      irq_source <= 3'h0;
      sfr_rdata <= 8'h00;
    end else begin
      irq_vector <= nxt_vector;
      irq_source <= nxt_source;
      sfr_rdata <= nxt_rdata;
    end
  end

  // quasi-bidirectional: drive low only, pull-up otherwise
  // pins stay usable as interrupt inputs while latch is high
  assign nibble_port_out = 4'h0;
  assign nibble_port_oe_n = port_ff;
  assign nibble_port_pullup = port_ff;
endmodule // eirq_top
`default_nettype wire

/* File: tb/eirq_pins.sv */
// partner: external interrupt sources pulling the nibble port pins low
`timescale 1ns/1ps
`default_nettype none
module eirq_pins (
  // from sources and port
  input wire logic [3:0] ext_low,
  input wire logic [3:0] oe_n,
  // pin level seen by the port
  output logic [3:0] pin_lvl
);
  // pull-up wins unless port or source pulls low
  assign pin_lvl = oe_n & ~ext_low;
endmodule // eirq_pins
`default_nettype wire

/* File: tb/eirq_chk.sv */
// checker: port and vector relations of the interrupt block
`timescale 1ns/1ps
`default_nettype none
module eirq_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  // interrupt
  input wire logic irq_req,
  input wire logic [7:0] irq_vector,
  input wire logic [2:0] irq_source,
  // pins
  input wire logic [3:0] nibble_port_in,
  input wire logic [3:0] nibble_port_out,
  input wire logic [3:0] nibble_port_oe_n,
  input wire logic [3:0] nibble_port_pullup
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_pin_low: assert property (nibble_port_out == 4'h0)
    else $error("port drives high");
  chk_pullup_oe: assert property (nibble_port_pullup == nibble_port_oe_n)
    else $error("pull-up and drive disagree");
  chk_hit_decode: assert property (sfr_hit == (sfr_addr == 8'hC0 || sfr_addr == 8'hD8))
    else $error("hit decode wrong");
  chk_vec_map: assert property (irq_req |=> irq_vector == {2'h0, irq_source, 3'h3})
    else $error("vector not matching source");
  chk_rdata_hold: assert property (!(sfr_rd && sfr_hit) |=> $stable(sfr_rdata))
    else $error("read data moved");
  chk_port_upper: assert property (sfr_rd && sfr_addr == 8'hD8 |=> sfr_rdata[7:4] == 4'hF)
    else $error("upper port bits not ones");
  chk_rmw_latch: assert property (sfr_rd && sfr_rmw && sfr_addr == 8'hD8
    |=> sfr_rdata[3:0] == $past(nibble_port_pullup))
    else $error("rmw read not latch");
  chk_pin_read: assert property (sfr_rd && !sfr_rmw && sfr_addr == 8'hD8 && $stable(nibble_port_in)
    |=> sfr_rdata[3:0] == $past(nibble_port_in))
    else $error("pin read wrong");
endmodule // eirq_chk
bind eirq_top eirq_chk u_chk (.clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
  .sfr_rmw(sfr_rmw), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .irq_req(irq_req),
  .irq_vector(irq_vector), .irq_source(irq_source), .nibble_port_in(nibble_port_in),
  .nibble_port_out(nibble_port_out), .nibble_port_oe_n(nibble_port_oe_n),
  .nibble_port_pullup(nibble_port_pullup));
`default_nettype wire

/* File: tb/testbench.sv */
// testbench: register, port and interrupt sequences
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import eirq_pkg::*;
  logic clk, reset_n, wr, rd, rmw, bw, bv, ack, reti, hit, irq;
  logic [7:0] addr, wd, ba, rdat, vec;
  logic [5:0] sreq, shigh;
  logic [3:0] ext, pin, pout, oen, pup;
  logic [2:0] src;
  int err_total, compares, cyc;
  eirq_top dut (.clk(clk), .reset_n(reset_n), .sfr_addr(addr), .sfr_wr(wr), .sfr_wdata(wd), .sfr_rd(rd),
    .sfr_rmw(rmw), .sfr_bit_wr(bw), .sfr_bit_addr(ba), .sfr_bit_val(bv), .sfr_rdata(rdat), .sfr_hit(hit),
    .std_req(sreq), .std_high(shigh), .irq_req(irq), .irq_vector(vec), .irq_source(src), .irq_ack(ack),
    .irq_reti(reti), .nibble_port_in(pin), .nibble_port_out(pout), .nibble_port_oe_n(oen),
    .nibble_port_pullup(pup));
  eirq_pins u_pins (.ext_low(ext), .oe_n(oen), .pin_lvl(pin));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task cmp1(input string nm, input logic e, input logic g);
    cmp8(nm, {7'h00, e}, {7'h00, g});
  endtask
  task wrb(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wd <= d; wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task wbit(input logic [7:0] a, input logic v);
    @(posedge clk);
    ba <= a; bv <= v; bw <= 1;
    @(posedge clk);
    bw <= 0;
  endtask
  task rdb(input logic [7:0] a, input logic m, input logic [7:0] e);
    @(posedge clk);
    addr <= a; rmw <= m; rd <= 1;
    @(posedge clk);
    rd <= 0;
    @(posedge clk);
    #1 cmp8("sfr_rdata", e, rdat);
  endtask
  task pulse(input logic r);
    @(posedge clk);
    if (r) reti <= 1; else ack <= 1;
    @(posedge clk);
    reti <= 0; ack <= 0;
    #1;
  endtask
  task wirq(input logic [2:0] s);
    int n;
    n = 0;
    // let inputs and registers of this edge settle before looking
    #1;
    while (irq !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    @(posedge clk);
    #1 cmp8("irq_vector", {2'h0, s, 3'h3}, vec);
    cmp8("irq_source", {5'h00, s}, {5'h00, src});
  endtask
  task finish_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ceiling well above the fewer than one hundred cycles the tests take
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      finish_test;
    end
  end
  initial begin
    {wr, rd, rmw, bw, bv, ack, reti, reset_n} = 0;
    {addr, wd, ba, sreq, shigh, ext} = 0;
    {err_total, compares, cyc} = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1;
    repeat (3) @(posedge clk);
    rdb(EIRQ_CTRL_ADDR, 0, 8'h00);
    rdb(EIRQ_PORT_ADDR, 1, 8'hFF);
    rdb(8'h80, 0, 8'hFF);
    $display("test reset done");
    wrb(EIRQ_PORT_ADDR, 8'h0A);
    rdb(EIRQ_PORT_ADDR, 0, 8'hFA);
    cmp8("nibble_port_oe_n", 8'h0A, {4'h0, oen});
    cmp8("nibble_port_pullup", 8'h0A, {4'h0, pup});
    cmp8("nibble_port_out", 8'h00, {4'h0, pout});
    wbit(8'hD8, 1);
    rdb(EIRQ_PORT_ADDR, 1, 8'hFB);
    wbit(8'hDC, 0);
    rdb(EIRQ_PORT_ADDR, 1, 8'hFB);
    wrb(EIRQ_PORT_ADDR, 8'h0F);
    $display("test port done");
    wbit(8'hC0, 1);
    wbit(8'hC2, 1);
    rdb(EIRQ_CTRL_ADDR, 0, 8'h05);
    ext[2] <= 1;
    wirq(3'h6);
    rdb(EIRQ_CTRL_ADDR, 0, 8'h07);
    pulse(0);
    rdb(EIRQ_CTRL_ADDR, 0, 8'h05);
    pulse(1);
    ext[2] <= 0;
    $display("test edge done");
    wrb(EIRQ_CTRL_ADDR, 8'h00);
    ext[3] <= 1;
    repeat (4) @(posedge clk);
    #1 cmp1("irq_req", 0, irq);
    sreq <= 6'h01;
    wrb(EIRQ_CTRL_ADDR, 8'hC0);
    wirq(3'h7);
    wrb(EIRQ_CTRL_ADDR, 8'h40);
    wirq(3'h0);
    ext[3] <= 0;
    sreq <= 0;
    repeat (3) @(posedge clk);
    #1 cmp1("irq_req", 0, irq);
    $display("test level done");
    for (int i = 0; i < 6; i++) begin
      sreq <= 6'(1 << i);
      wirq(3'(i));
    end
    sreq <= 6'h01;
    wirq(3'h0);
    pulse(0);
    repeat (2) @(posedge clk);
    #1 cmp1("irq_req", 0, irq);
    shigh <= 6'h02;
    sreq <= 6'h03;
    wirq(3'h1);
    $display("test nesting done");
    finish_test;
  end
endmodule // testbench
`default_nettype wire
